// >>> logic/lc_loop_code_top.sv
// In-band loop code block: AHB-Lite registers, transmit generator, three detectors.
// Assumes a framer that strobes line bits in both directions on clk.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "lc_params.svh"

module lc_loop_code_top #(
    parameter int unsigned INTEG_CYCLES = `LC_INTEG_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire lc_pkg::lc_tx_in_t tx_in,
    output lc_pkg::lc_bit_t tx_out,
    input wire lc_pkg::lc_bit_t rx_in,
    output logic interrupt_out_n
);
    import lc_pkg::*;

    typedef struct packed {
        logic [7:0] rx_code_length_control;
        logic [7:0] rx_spare_code_control;
        logic [7:0] rx_loop_code_latched_status;
        logic [7:0] rx_loop_code_irq_mask;
        logic [7:0] rx_up_code_def_1;
        logic [7:0] rx_up_code_def_2;
        logic [7:0] rx_down_code_def_1;
        logic [7:0] rx_down_code_def_2;
        logic [7:0] rx_spare_code_def_1;
        logic [7:0] rx_spare_code_def_2;
        logic [7:0] mode_control;
        logic [7:0] tx_control_three;
        logic [7:0] tx_control_four;
        logic [7:0] tx_code_def_1;
        logic [7:0] tx_code_def_2;
    } lc_regs_t;

    typedef struct packed {
        lc_regs_t regs;
        lc_bus_state_t bus;
        logic [8:0] idx;
        logic wr;
        logic [31:0] rdata;
        logic rdy;
        logic [2:0] det_prev;
        logic restart_up;
        logic restart_down;
        logic restart_spare;
        logic irq_n;
    } lc_top_state_t;

    lc_top_state_t s_q;
    lc_top_state_t s_d;
    logic [2:0] det_live;
    logic t1_mode;
    logic accept;
    logic [7:0] wbyte;
    logic [7:0] events;
    logic [7:0] clear_mask;

    // Returns the current value of the register at a word index.
    function automatic logic [7:0] reg_read(input logic [8:0] idx, input lc_regs_t r,
                                            input logic [2:0] live);
        case (idx)
            `LC_IDX_RX_LEN_CTRL: begin
                reg_read = r.rx_code_length_control;
            end
            `LC_IDX_RX_SPARE_CTRL: begin
                reg_read = r.rx_spare_code_control;
            end
            `LC_IDX_RX_LATCHED: begin
                reg_read = r.rx_loop_code_latched_status;
            end
            `LC_IDX_RX_IRQ_MASK: begin
                reg_read = r.rx_loop_code_irq_mask;
            end
            `LC_IDX_RX_UP_DEF1: begin
                reg_read = r.rx_up_code_def_1;
            end
            `LC_IDX_RX_UP_DEF2: begin
                reg_read = r.rx_up_code_def_2;
            end
            `LC_IDX_RX_DOWN_DEF1: begin
                reg_read = r.rx_down_code_def_1;
            end
            `LC_IDX_RX_DOWN_DEF2: begin
                reg_read = r.rx_down_code_def_2;
            end
            `LC_IDX_RX_SPARE_DEF1: begin
                reg_read = r.rx_spare_code_def_1;
            end
            `LC_IDX_RX_SPARE_DEF2: begin
                reg_read = r.rx_spare_code_def_2;
            end
            `LC_IDX_RX_LIVE: begin
                reg_read = {5'b00000, live};
            end
            `LC_IDX_MODE_CTRL: begin
                reg_read = r.mode_control;
            end
            `LC_IDX_TX_CTRL3: begin
                reg_read = r.tx_control_three;
            end
            `LC_IDX_TX_CTRL4: begin
                reg_read = r.tx_control_four;
            end
            `LC_IDX_TX_DEF1: begin
                reg_read = r.tx_code_def_1;
            end
            `LC_IDX_TX_DEF2: begin
                reg_read = r.tx_code_def_2;
            end
            default: begin
                reg_read = 8'h00;
            end
        endcase
    endfunction

    assign t1_mode = s_q.regs.mode_control[`LC_MODE_T1_BIT];

    always_comb begin
        s_d = s_q;
        s_d.restart_up = 1'b0;
        s_d.restart_down = 1'b0;
        s_d.restart_spare = 1'b0;
        accept = hsel && hready && htrans[1];
        wbyte = hwdata[7:0];
        clear_mask = 8'h00;

        case (s_q.bus)
            LC_BUS_IDLE: begin
                if (accept) begin
                    s_d.idx = haddr[10:2];
                    s_d.wr = hwrite;
                    s_d.rdy = 1'b0;
                    s_d.bus = LC_BUS_DATA;
                end
            end
            LC_BUS_DATA: begin
                s_d.rdy = 1'b1;
                s_d.bus = LC_BUS_IDLE;
                if (s_q.wr) begin
                    case (s_q.idx)
                        `LC_IDX_RX_LEN_CTRL: begin
                            s_d.regs.rx_code_length_control = wbyte;
                        end
                        `LC_IDX_RX_SPARE_CTRL: begin
                            s_d.regs.rx_spare_code_control = wbyte;
                        end
                        `LC_IDX_RX_LATCHED: begin
                            clear_mask = wbyte;
                        end
                        `LC_IDX_RX_IRQ_MASK: begin
                            s_d.regs.rx_loop_code_irq_mask = wbyte;
                        end
                        `LC_IDX_RX_UP_DEF1: begin
                            s_d.regs.rx_up_code_def_1 = wbyte;
                            s_d.restart_up = 1'b1;
                        end
                        `LC_IDX_RX_UP_DEF2: begin
                            s_d.regs.rx_up_code_def_2 = wbyte;
                            s_d.restart_up = 1'b1;
                        end
                        `LC_IDX_RX_DOWN_DEF1: begin
                            s_d.regs.rx_down_code_def_1 = wbyte;
                            s_d.restart_down = 1'b1;
                        end
                        `LC_IDX_RX_DOWN_DEF2: begin
                            s_d.regs.rx_down_code_def_2 = wbyte;
                            s_d.restart_down = 1'b1;
                        end
                        `LC_IDX_RX_SPARE_DEF1: begin
                            s_d.regs.rx_spare_code_def_1 = wbyte;
                            s_d.restart_spare = 1'b1;
                        end
                        `LC_IDX_RX_SPARE_DEF2: begin
                            s_d.regs.rx_spare_code_def_2 = wbyte;
                            s_d.restart_spare = 1'b1;
                        end
                        `LC_IDX_MODE_CTRL: begin
                            s_d.regs.mode_control = wbyte;
                        end
                        `LC_IDX_TX_CTRL3: begin
                            s_d.regs.tx_control_three = wbyte;
                        end
                        `LC_IDX_TX_CTRL4: begin
                            s_d.regs.tx_control_four = wbyte;
                        end
                        `LC_IDX_TX_DEF1: begin
                            s_d.regs.tx_code_def_1 = wbyte;
                        end
                        `LC_IDX_TX_DEF2: begin
                            s_d.regs.tx_code_def_2 = wbyte;
                        end
                        default: begin
                            clear_mask = 8'h00;
                        end
                    endcase
                end else begin
                    s_d.rdata = {24'h00_0000, reg_read(s_q.idx, s_q.regs, det_live)};
                end
            end
            default: begin
                s_d.bus = LC_BUS_IDLE;
                s_d.rdy = 1'b1;
            end
        endcase

        // Detection edges become latched set and clear events.
        events = 8'h00;
        events[`LC_ST_UP_SET_BIT] = det_live[0] && !s_q.det_prev[0];
        events[`LC_ST_DOWN_SET_BIT] = det_live[1] && !s_q.det_prev[1];
        events[`LC_ST_SPARE_SET_BIT] = det_live[2] && !s_q.det_prev[2];
        events[`LC_ST_UP_CLR_BIT] = !det_live[0] && s_q.det_prev[0];
        events[`LC_ST_DOWN_CLR_BIT] = !det_live[1] && s_q.det_prev[1];
        events[`LC_ST_SPARE_CLR_BIT] = !det_live[2] && s_q.det_prev[2];
        s_d.det_prev = det_live;

        // A new event wins over a clear written in the same cycle.
        s_d.regs.rx_loop_code_latched_status =
            (s_q.regs.rx_loop_code_latched_status & ~clear_mask) | events;

        s_d.irq_n = ~|(s_d.regs.rx_loop_code_latched_status
                       & s_d.regs.rx_loop_code_irq_mask);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
            s_q.irq_n <= 1'b1;
            s_q.bus <= LC_BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    lc_code_gen u_gen (
        .clk(clk),
        .reset(reset),
        .tx_in(tx_in),
        .enable(t1_mode && s_q.regs.tx_control_three[`LC_TX_LOOP_EN_BIT]),
        .fbit_insert(!s_q.regs.mode_control[`LC_MODE_NO_FBIT_BIT]),
        .def1(s_q.regs.tx_code_def_1),
        .def2(s_q.regs.tx_code_def_2),
        .len_sel(s_q.regs.tx_control_four[`LC_TX_LEN_LSB +: 2]),
        .tx_out(tx_out)
    );

    lc_code_detector #(.WINDOW_CYCLES(INTEG_CYCLES)) u_det_up (
        .clk(clk),
        .reset(reset),
        .enable(t1_mode),
        .restart(s_q.restart_up),
        .rx_in(rx_in),
        .def1(s_q.regs.rx_up_code_def_1),
        .def2(s_q.regs.rx_up_code_def_2),
        .len_sel(s_q.regs.rx_code_length_control[`LC_RX_UP_LEN_LSB +: 3]),
        .detected(det_live[0])
    );

    lc_code_detector #(.WINDOW_CYCLES(INTEG_CYCLES)) u_det_down (
        .clk(clk),
        .reset(reset),
        .enable(t1_mode),
        .restart(s_q.restart_down),
        .rx_in(rx_in),
        .def1(s_q.regs.rx_down_code_def_1),
        .def2(s_q.regs.rx_down_code_def_2),
        .len_sel(s_q.regs.rx_code_length_control[`LC_RX_DOWN_LEN_LSB +: 3]),
        .detected(det_live[1])
    );

    lc_code_detector #(.WINDOW_CYCLES(INTEG_CYCLES)) u_det_spare (
        .clk(clk),
        .reset(reset),
        .enable(t1_mode),
        .restart(s_q.restart_spare),
        .rx_in(rx_in),
        .def1(s_q.regs.rx_spare_code_def_1),
        .def2(s_q.regs.rx_spare_code_def_2),
        .len_sel(s_q.regs.rx_spare_code_control[`LC_RX_SPARE_LEN_LSB +: 3]),
        .detected(det_live[2])
    );

    assign hreadyout = s_q.rdy;
    assign hrdata = s_q.rdata;
    assign hresp = 1'b0;
    assign interrupt_out_n = s_q.irq_n;
endmodule
`default_nettype wire

// >>> logic/lc_params.svh
// Constants for the in-band loop code generator and detectors.
// Assumes the includer uses the AHB-Lite word index (byte address / 4).
`ifndef LC_PARAMS_SVH
`define LC_PARAMS_SVH

`define LC_IDX_RX_LEN_CTRL 9'h082
`define LC_IDX_RX_LATCHED 9'h092
`define LC_IDX_RX_SPARE_DEF1 9'h09c
`define LC_IDX_RX_SPARE_DEF2 9'h09d
`define LC_IDX_RX_SPARE_CTRL 9'h09f
`define LC_IDX_RX_IRQ_MASK 9'h0a2
`define LC_IDX_RX_UP_DEF1 9'h0ac
`define LC_IDX_RX_UP_DEF2 9'h0ad
`define LC_IDX_RX_DOWN_DEF1 9'h0ae
`define LC_IDX_RX_DOWN_DEF2 9'h0af
`define LC_IDX_RX_LIVE 9'h0b2
`define LC_IDX_MODE_CTRL 9'h0c0
`define LC_IDX_TX_CTRL3 9'h183
`define LC_IDX_TX_CTRL4 9'h186
`define LC_IDX_TX_DEF1 9'h1ac
`define LC_IDX_TX_DEF2 9'h1ad

`define LC_TX_LOOP_EN_BIT 0
`define LC_TX_LEN_LSB 0
`define LC_MODE_T1_BIT 0
`define LC_MODE_NO_FBIT_BIT 1
`define LC_RX_UP_LEN_LSB 3
`define LC_RX_DOWN_LEN_LSB 0
`define LC_RX_SPARE_LEN_LSB 0
`define LC_ST_UP_SET_BIT 0
`define LC_ST_DOWN_SET_BIT 1
`define LC_ST_SPARE_SET_BIT 2
`define LC_ST_UP_CLR_BIT 4
`define LC_ST_DOWN_CLR_BIT 5
`define LC_ST_SPARE_CLR_BIT 6

`define LC_REG_RESET 8'h00
`define LC_FRAME_BITS 193
`define LC_INTEG_MS 48
`define LC_CLK_KHZ 100000
`define LC_INTEG_CYCLES (`LC_INTEG_MS * `LC_CLK_KHZ)
`define LC_MISS_SHIFT 3

`endif

// >>> logic/lc_pkg.sv
// Types shared by the loop code generator, detectors and register block.
// Assumes nothing of its surroundings.
package lc_pkg;

    typedef enum logic [0:0] {
        LC_BUS_IDLE = 1'b0,
        LC_BUS_DATA = 1'b1
    } lc_bus_state_t;

    typedef struct packed {
        logic valid;
        logic data;
    } lc_bit_t;

    typedef struct packed {
        logic strobe;
        logic frame_start;
        logic payload_bit;
        logic fbit_value;
    } lc_tx_in_t;

    // Receive length select: 0..6 give 1..7 bits, 7 gives 16 bits.
    function automatic logic [4:0] lc_rx_len(input logic [2:0] sel);
        lc_rx_len = (sel == 3'h7) ? 5'h10 : {2'b00, sel} + 5'h01;
    endfunction

    // Transmit length select: 0, 1, 2 give 5, 6, 7 bits, 3 gives 16 bits.
    function automatic logic [4:0] lc_tx_len(input logic [1:0] sel);
        lc_tx_len = (sel == 2'h3) ? 5'h10 : {3'b000, sel} + 5'h05;
    endfunction

    // Left-aligned code, first bit sent at bit 15.
    function automatic logic [15:0] lc_code16(input logic [7:0] d1, input logic [7:0] d2,
                                              input logic [4:0] len);
        lc_code16 = (len == 5'h10) ? {d1, d2} : {d1, 8'h00};
    endfunction

endpackage

// >>> logic/lc_code_gen.sv
// Transmit loop code generator, one line bit per strobe.
// Assumes the framer strobes once per line bit and marks the F-bit slot.
`timescale 1ns/10ps
`default_nettype none
module lc_code_gen (
    input wire logic clk,
    input wire logic reset,
    input wire lc_pkg::lc_tx_in_t tx_in,
    input wire logic enable,
    input wire logic fbit_insert,
    input wire logic [7:0] def1,
    input wire logic [7:0] def2,
    input wire logic [1:0] len_sel,
    output lc_pkg::lc_bit_t tx_out
);
    import lc_pkg::*;

    typedef struct packed {
        logic [7:0] pos;
        logic [3:0] ph;
        lc_bit_t out;
    } lc_gen_state_t;

    lc_gen_state_t s_q;
    lc_gen_state_t s_d;
    logic [4:0] len;
    logic [15:0] code;

    always_comb begin
        s_d = s_q;
        len = lc_tx_len(len_sel);
        code = lc_code16(def1, def2, len);
        s_d.out.valid = tx_in.strobe;
        if (tx_in.strobe) begin
            s_d.out.data = tx_in.payload_bit;
            if (enable) begin
                s_d.out.data = code[4'hf - s_q.ph];
                s_d.ph = ({1'b0, s_q.ph} == len - 5'h01) ? 4'h0 : s_q.ph + 4'h1;
            end
            if ((tx_in.frame_start || s_q.pos == 8'h00) && fbit_insert) begin
                s_d.out.data = tx_in.fbit_value;
            end
            if (tx_in.frame_start) begin
                s_d.pos = 8'h01;
            end else if (s_q.pos == 8'(`LC_FRAME_BITS - 1)) begin
                s_d.pos = 8'h00;
            end else begin
                s_d.pos = s_q.pos + 8'h01;
            end
        end
        // The phase waits at the first code bit while the loop is off.
        if (!enable) begin
            s_d.ph = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_out = s_q.out;
endmodule
`default_nettype wire

// >>> logic/lc_code_detector.sv
// One programmable repeating-code detector with a timed integration window.
// Assumes one received line bit per valid strobe, framed or unframed.
`timescale 1ns/10ps
`default_nettype none
module lc_code_detector #(
    parameter int unsigned WINDOW_CYCLES = 4800000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic restart,
    input wire lc_pkg::lc_bit_t rx_in,
    input wire logic [7:0] def1,
    input wire logic [7:0] def2,
    input wire logic [2:0] len_sel,
    output logic detected
);
    import lc_pkg::*;

    typedef struct packed {
        logic [15:0] hist;
        logic [3:0] ph;
        logic [31:0] win;
        logic [31:0] bits;
        logic [31:0] misses;
        logic det;
    } lc_det_state_t;

    lc_det_state_t s_q;
    lc_det_state_t s_d;
    logic [4:0] len;
    logic [15:0] code;
    logic [15:0] mask;

    always_comb begin
        s_d = s_q;
        len = lc_rx_len(len_sel);
        code = lc_code16(def1, def2, len);
        mask = 16'hffff >> (5'h10 - len);
        if (rx_in.valid) begin
            s_d.hist = {s_q.hist[14:0], rx_in.data};
            s_d.bits = s_q.bits + 32'h0000_0001;
            if (rx_in.data != code[4'hf - s_q.ph]) begin
                s_d.misses = s_q.misses + 32'h0000_0001;
            end
            s_d.ph = ({1'b0, s_q.ph} == len - 5'h01) ? 4'h0 : s_q.ph + 4'h1;
            if (((s_d.hist ^ (code >> (5'h10 - len))) & mask) == 16'h0000) begin
                s_d.ph = 4'h0;
            end
        end
        if (s_q.win == WINDOW_CYCLES - 1) begin
            s_d.win = '0;
            s_d.bits = '0;
            s_d.misses = '0;
            s_d.det = (s_q.bits != 0) && ((s_q.misses << `LC_MISS_SHIFT) < s_q.bits);
        end else begin
            s_d.win = s_q.win + 32'h0000_0001;
        end
        if (restart || !enable) begin
            s_d.win = '0;
            s_d.bits = '0;
            s_d.misses = '0;
        end
        if (!enable) begin
            s_d.det = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign detected = s_q.det;
endmodule
`default_nettype wire

// >>> dv/lc_line_model.sv
// Far-end line model: framer bit strobes toward the block and received code bits.
// Assumes the bench gives the received code left aligned and its length.
`timescale 1ns/10ps
`default_nettype none
module lc_line_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic [15:0] rx_code,
    input wire logic [4:0] rx_len,
    input wire logic fbit_add,
    output lc_pkg::lc_tx_in_t tx_in,
    output lc_pkg::lc_bit_t rx_in
);
    import lc_pkg::*;
    logic [1:0] div_q;
    int k_q, m_q, f_q;
    logic st, ins, err;
    initial begin
        tx_in = '0;
        rx_in = '0;
        div_q = 2'h0;
        k_q = 0;
        m_q = 0;
        f_q = 0;
    end
    always @(posedge clk) begin
        st = run && div_q == 2'h0 && !reset;
        ins = fbit_add && f_q == 192;
        err = !fbit_add && $urandom_range(255) == 0;
        div_q <= div_q + 2'h1;
        tx_in.strobe <= st;
        tx_in.frame_start <= st ? k_q % 193 == 0 : 1'($urandom);
        tx_in.payload_bit <= 1'($urandom);
        tx_in.fbit_value <= 1'($urandom);
        k_q <= !run ? 0 : k_q + int'(st);
        rx_in.valid <= div_q == 2'h2 && !reset;
        if (div_q == 2'h2) begin
            rx_in.data <= ins ? 1'($urandom) : rx_code[15 - m_q % rx_len] ^ err;
            m_q <= ins ? m_q : m_q + 1;
            f_q <= f_q == 192 ? 0 : f_q + 1;
        end else begin
            rx_in.data <= 1'($urandom);
        end
    end
endmodule
`default_nettype wire

// >>> dv/lc_loop_code_top_assertions.sv
// Port checks for the loop code block, bound into its top module.
// Assumes one clock domain with synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module lc_loop_code_checker #(
    parameter int unsigned INTEG_CYCLES = 200
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire lc_pkg::lc_tx_in_t tx_in,
    input wire lc_pkg::lc_bit_t tx_out,
    input wire lc_pkg::lc_bit_t rx_in,
    input wire logic interrupt_out_n
);
    import lc_pkg::*;
    logic wr;
    assign wr = hsel && hready && hreadyout && htrans[1] && hwrite;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_take;
        hsel && hready && hreadyout && htrans[1];
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_wait;
        s_take |=> s_wait;
    endproperty
    a_wait: assert property (p_wait) else $error("Wait state wrong.");
    property p_cause;
        $fell(hreadyout) |-> $past(hsel && hready && htrans[1]);
    endproperty
    a_cause: assert property (p_cause) else $error("Wait without request.");
    property p_okay;
        hresp == 1'b0 && hrdata[31:8] == 24'h00_0000;
    endproperty
    a_okay: assert property (p_okay) else $error("Response or upper data wrong.");
    property p_hold;
        $changed(hrdata) |-> $past(!hreadyout);
    endproperty
    a_hold: assert property (p_hold) else $error("Read data moved.");
    property p_tx;
        tx_in.strobe |=> tx_out.valid;
    endproperty
    a_tx: assert property (p_tx) else $error("No bit after strobe.");
    property p_quiet;
        !tx_in.strobe |=> !tx_out.valid && $stable(tx_out.data);
    endproperty
    a_quiet: assert property (p_quiet) else $error("Bit without strobe.");
    property p_rel;
        $rose(interrupt_out_n) |-> $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
    endproperty
    a_rel: assert property (p_rel) else $error("Interrupt released alone.");
    property p_rst;
        disable iff (1'b0) reset |=> interrupt_out_n && hreadyout && !tx_out.valid;
    endproperty
    a_rst: assert property (p_rst) else $error("Reset state wrong.");
endmodule
bind lc_loop_code_top lc_loop_code_checker #(.INTEG_CYCLES(INTEG_CYCLES)) i_chk (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .tx_in(tx_in), .tx_out(tx_out), .rx_in(rx_in),
    .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// >>> dv/lc_loop_code_top_tb.sv
// Self-checking bench for the loop code block.
// Assumes the line model on the far side and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "lc_params.svh"
module lc_loop_code_top_tb;
    import lc_pkg::*;
    logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, interrupt_out_n;
    logic run, fbit_add, pend, exp_b, tx_en, nofb;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans, ls;
    logic [2:0] hsize;
    logic [15:0] rx_code, exp_code;
    logic [4:0] rx_len;
    logic [7:0] d1, d2;
    logic [8:0] ridx [3] = '{`LC_IDX_RX_LATCHED, `LC_IDX_TX_CTRL3, 9'h1ff};
    int failures, n_compared, n, exp_len, t, seed;
    lc_tx_in_t tx_in;
    lc_bit_t tx_out, rx_in;
    assign hready = hreadyout;
    lc_loop_code_top #(.INTEG_CYCLES(200)) i_dut (.clk(clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_in(tx_in),
        .tx_out(tx_out), .rx_in(rx_in), .interrupt_out_n(interrupt_out_n));
    lc_line_model i_line (.clk(clk), .reset(reset), .run(run), .rx_code(rx_code),
        .rx_len(rx_len), .fbit_add(fbit_add), .tx_in(tx_in), .rx_in(rx_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("Compared %0d, failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [8:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {21'h00_0000, idx, 2'b00};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_rdy();
        r = hrdata;
    endtask
    task automatic poll(input logic [7:0] e);
        for (int k = 0; k < 200; k++) begin
            bus(1'b0, `LC_IDX_RX_LIVE, 8'h00);
            if (r[7:0] === e) break;
            repeat (10) @(posedge clk);
        end
        chk("live status", {24'h00_0000, e}, r);
    endtask
    always @(posedge clk) begin
        if (pend) chk("tx_out", {30'h0000_0000, 1'b1, exp_b}, {30'h0000_0000, tx_out});
        pend = tx_in.strobe;
        exp_b = (tx_in.frame_start && !nofb) ? tx_in.fbit_value : !tx_en ? tx_in.payload_bit :
            exp_code[15 - n % exp_len];
        n = tx_in.strobe ? n + 1 : n;
        n = run ? n : 0;
    end
    initial begin
        {reset, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 68'h0, 3'h2};
        {run, fbit_add, pend, tx_en, nofb, n, exp_len, exp_code} = {5'h00, 32'h0, 32'h5, 16'h0};
        seed = $urandom(32'h9147_1b19);
        rx_code = 16'($urandom);
        rx_len = 5'h10;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (t = 0; t < 3; t++) begin
            bus(1'b0, ridx[t], 8'h00);
            chk("reset value", 32'h0000_0000, r);
        end
        bus(1'b1, `LC_IDX_RX_UP_DEF1, rx_code[15:8]);
        bus(1'b1, `LC_IDX_RX_UP_DEF2, rx_code[7:0]);
        bus(1'b1, `LC_IDX_RX_DOWN_DEF1, 8'h3c);
        bus(1'b1, `LC_IDX_RX_DOWN_DEF2, 8'h3c);
        bus(1'b1, `LC_IDX_RX_SPARE_DEF1, 8'h80);
        bus(1'b1, `LC_IDX_RX_SPARE_CTRL, 8'h04);
        bus(1'b1, `LC_IDX_RX_LEN_CTRL, 8'h3f);
        bus(1'b1, `LC_IDX_RX_IRQ_MASK, 8'h01);
        for (t = 0; t < 6; t++) begin
            bus(1'b1, `LC_IDX_TX_CTRL3, 8'h00);
            ls = t == 0 ? 2'h0 : 2'(t - 1);
            d1 = t == 0 ? 8'h80 : 8'($urandom);
            d2 = 8'($urandom);
            exp_len <= ls == 2'h3 ? 16 : ls + 5;
            exp_code <= ls == 2'h3 ? {d1, d2} : {d1, 8'h00};
            nofb <= t == 4;
            tx_en <= t < 5;
            bus(1'b1, `LC_IDX_TX_DEF1, d1);
            bus(1'b1, `LC_IDX_TX_DEF2, d2);
            bus(1'b1, `LC_IDX_TX_CTRL4, {6'h00, ls});
            bus(1'b1, `LC_IDX_MODE_CTRL, {6'h00, t == 4, 1'b1});
            bus(1'b1, `LC_IDX_TX_CTRL3, {7'h00, t < 5});
            run <= 1'b1;
            repeat (1000) @(posedge clk);
            run <= 1'b0;
            repeat (4) @(posedge clk);
        end
        poll(8'h01);
        chk("irq", 32'h0, 32'(interrupt_out_n));
        bus(1'b0, `LC_IDX_RX_LATCHED, 8'h00);
        chk("latched", 32'h0000_0001, r);
        bus(1'b1, `LC_IDX_RX_LATCHED, 8'h01);
        repeat (4) @(posedge clk);
        chk("irq", 32'h1, 32'(interrupt_out_n));
        rx_code <= 16'h8000;
        rx_len <= 5'h05;
        fbit_add <= 1'b1;
        poll(8'h04);
        bus(1'b0, `LC_IDX_RX_LATCHED, 8'h00);
        chk("latched", 32'h0000_0014, r);
        chk("irq", 32'h1, 32'(interrupt_out_n));
        bus(1'b1, `LC_IDX_RX_IRQ_MASK, 8'h14);
        repeat (4) @(posedge clk);
        chk("irq", 32'h0, 32'(interrupt_out_n));
        bus(1'b1, `LC_IDX_MODE_CTRL, 8'h00);
        poll(8'h00);
        bus(1'b1, `LC_IDX_RX_LATCHED, 8'h77);
        bus(1'b0, `LC_IDX_RX_LATCHED, 8'h00);
        chk("latched", 32'h0000_0000, r);
        chk("irq", 32'h1, 32'(interrupt_out_n));
        print_verdict();
    end
endmodule
`default_nettype wire
